// ### core/rwl_pkg.sv
package rwl_pkg;
   // register byte offsets on the special function register bus
   localparam logic [7:0] OFS_OPTION_CONTROL = 8'h94;
   localparam logic [7:0] OFS_SOFTWARE_COMMAND = 8'h97;
   localparam logic [7:0] OFS_DETECTOR_POWER_DOWN = 8'hE5;
   localparam logic [7:0] OFS_AUX_CONTROL_TWO = 8'hF7;
   localparam logic [7:0] OFS_AUX_CONTROL_ONE = 8'hF8;
   // flash address of the configuration word block
   localparam logic [15:0] CFG_BLOCK_BASE = 16'h1FF0;
   localparam int CFG_BLOCK_BYTES = 16;
   localparam logic [15:0] CFG_WORD_HIGH_ADDR = 16'h1FFF;
   // reset values
   localparam logic [7:0] RST_OPTION_CONTROL = 8'h00;
   localparam logic [7:0] RST_DETECTOR_POWER_DOWN = 8'h00;
   localparam logic [7:0] RST_AUX_CONTROL_TWO = 8'h06;
   localparam logic [7:0] RST_AUX_CONTROL_ONE = 8'h00;
   localparam logic [7:0] RST_CONFIG_WORD = 8'h00;
   // storable bits of the first auxiliary register
   localparam logic [7:0] AUXILIARY_CONTROL_ONE_RW_MASK = 8'h5D;
   // field positions
   localparam int PERIOD_SEL_LSB = 4;
   localparam int WDT_CTRL_LSB = 6;
   localparam int POWER_SAVE_BIT = 5;
   localparam int WDT_CLEAR_BIT = 7;
   localparam int WDT_STATUS_BIT = 1;
   localparam int PIN_ENABLE_BIT = 6;
   localparam int UV_SEL_LSB = 4;
   // command codes
   localparam logic [7:0] CMD_SOFT_RESET = 8'h56;
   localparam logic [7:0] CMD_DETECT_ALL_OFF = 8'h37;
   localparam logic [7:0] CMD_DETECT_UV_OFF = 8'h38;
   // cpu operation modes as driven on the mode port
   localparam logic [1:0] MODE_FAST = 2'h0;
   localparam logic [1:0] MODE_SLOW = 2'h1;
   localparam logic [1:0] MODE_IDLE = 2'h2;
   localparam logic [1:0] MODE_STOP = 2'h3;
   // timing
   localparam int CLOCK_HZ = 10000000;
   localparam int WARMUP_MS = 25;
   localparam int WARMUP_CYC = CLOCK_HZ / 1000 * WARMUP_MS;
   localparam int SRC_HZ = 80000;
   localparam int PIN_LOW_TICKS = 2;
   localparam int WDT_MS_SEL0 = 400;
   localparam int WDT_MS_SEL1 = 200;
   localparam int WDT_MS_SEL2 = 100;
   localparam int WDT_MS_SEL3 = 50;
   localparam int WDT_TICKS_SEL0 = SRC_HZ / 1000 * WDT_MS_SEL0;
   localparam int WDT_TICKS_SEL1 = SRC_HZ / 1000 * WDT_MS_SEL1;
   localparam int WDT_TICKS_SEL2 = SRC_HZ / 1000 * WDT_MS_SEL2;
   localparam int WDT_TICKS_SEL3 = SRC_HZ / 1000 * WDT_MS_SEL3;
   localparam int RST_HOLD_CYC = 16;
   // sequencer states
   typedef enum logic [1:0] {ST_WARMUP, ST_LOAD, ST_HOLD, ST_RUN} rwl_state_t;
endpackage

// ### core/rwl_wdt.sv
`timescale 1ns/1ns
`default_nettype none
module rwl_wdt #(
   parameter int CNT_W = 15
) (
   input wire logic clk, // system clock
   input wire logic srst, // synchronous reset, also any chip reset
   input wire logic tick, // one slow rc period elapsed
   input wire logic run, // time base allowed to count
   input wire logic clear, // software clear strobe
   input wire logic [1:0] period_sel, // overflow period select
   output logic overflow // one-cycle pulse at terminal count
);
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;
   logic [CNT_W-1:0] limit;
   logic at_limit;

   ////////////////////////////////////////////////////////////////////////
   // period lookup in slow rc ticks
   assign limit = (period_sel == 2'h0) ? CNT_W'(rwl_pkg::WDT_TICKS_SEL0 - 1) :
                  (period_sel == 2'h1) ? CNT_W'(rwl_pkg::WDT_TICKS_SEL1 - 1) :
                  (period_sel == 2'h2) ? CNT_W'(rwl_pkg::WDT_TICKS_SEL2 - 1) :
                                         CNT_W'(rwl_pkg::WDT_TICKS_SEL3 - 1);
   // a shortened period while counting above it still overflows on the next counting tick
   assign at_limit = run && tick && (count_ff >= limit);
   assign nxt_count = (clear || at_limit) ? '0 :
                      (run && tick) ? count_ff + CNT_W'(1) : count_ff;

   // counter only advances on slow rc ticks
   always_ff @(posedge clk) begin
      if (srst) begin
         count_ff <= '0;
         overflow <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         overflow <= at_limit && !clear;
      end
   end
endmodule
`default_nettype wire

// ### core/rwl_reset_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module rwl_reset_ctrl #(
   parameter int WARMUP_CYCLES = rwl_pkg::WARMUP_CYC,
   parameter int HOLD_CYCLES = rwl_pkg::RST_HOLD_CYC
) (
   input wire logic CLOCK, // system clock, 10 MHz
   input wire logic SRST, // power-up reset of this block, active high
   input wire logic POR_EVENT, // supply monitor power-on event
   input wire logic UV_LOW, // supply below the selected trip level
   input wire logic EXT_RESET_N, // reset pin, active low
   input wire logic SRC_CLK, // slow rc clock level, sampled
   input wire logic [1:0] CPU_MODE, // fast, slow, idle or stop
   input wire logic [7:0] SFR_ADDR, // register address
   input wire logic SFR_WR, // register write strobe
   input wire logic SFR_RD, // register read strobe
   input wire logic [7:0] SFR_WDATA, // register write data
   output logic [7:0] SFR_RDATA, // register read data, one cycle after strobe
   output logic [15:0] FLASH_ADDR, // configuration fetch address
   output logic FLASH_RD, // configuration fetch strobe
   input wire logic [7:0] FLASH_RDATA, // fetch data, one cycle after strobe
   output logic CHIP_RESET, // chip reset, active high
   output logic [7:0] CFG_WORD_HIGH, // loaded high configuration byte
   output logic [1:0] UV_THRESH_SEL, // trip level select to supply monitor
   output logic UV_DETECT_EN, // low-voltage detector enable
   output logic POR_DETECT_EN, // power-on detector enable
   output logic POWER_SAVE, // reduced power in idle and stop
   output logic WDT_CLOCK_RUN // slow time base kept alive for watchdog
);
   localparam int WCNT_W = $clog2(WARMUP_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////
   // registers
   rwl_pkg::rwl_state_t state_ff;
   rwl_pkg::rwl_state_t nxt_state;
   logic [WCNT_W-1:0] cnt_ff;
   logic [WCNT_W-1:0] nxt_cnt;
   logic [4:0] load_idx_ff;
   logic [7:0] option_ff;
   logic [7:0] pdown_ff;
   logic [7:0] auxiliary_control_two_ff;
   logic [7:0] auxiliary_control_one_ff;
   logic [7:0] cfg_ff;
   logic wdt_status_ff;
   logic src_prev_ff;
   logic [1:0] pin_low_ticks_ff;
   logic [7:0] rdata_ff;

   ////////////////////////////////////////////////////////////////////////
   // decoded wires
   logic in_fast;
   logic in_slow;
   logic in_idle_stop;
   logic src_tick;
   logic wr_option;
   logic wr_cmd;
   logic wr_pdown;
   logic wr_auxiliary_control_two;
   logic wr_auxiliary_control_one;
   logic soft_req;
   logic pin_req;
   logic wdt_req;
   logic uv_req;
   logic por_req;
   logic any_warm_req;
   logic wdt_overflow;
   logic wdt_run;
   logic wdt_clear;
   logic wdt_rst_en;
   logic pdown_all;
   logic pdown_uv;
   logic running;
   logic [1:0] wdt_ctrl;
   logic [7:0] rd_sel;
   logic [7:0] auxiliary_control_one_clr_mask;

   // single bit mask of the self-clearing watchdog clear strobe
   assign auxiliary_control_one_clr_mask = 8'h01 << rwl_pkg::WDT_CLEAR_BIT;
   // mode decode
   assign in_fast = CPU_MODE == rwl_pkg::MODE_FAST;
   assign in_slow = CPU_MODE == rwl_pkg::MODE_SLOW;
   assign in_idle_stop = (CPU_MODE == rwl_pkg::MODE_IDLE) ||
                         (CPU_MODE == rwl_pkg::MODE_STOP);
   assign running = state_ff == rwl_pkg::ST_RUN;

   // register write decode; writes during chip reset are dropped
   assign wr_option = running && SFR_WR && (SFR_ADDR == rwl_pkg::OFS_OPTION_CONTROL);
   assign wr_cmd = running && SFR_WR && (SFR_ADDR == rwl_pkg::OFS_SOFTWARE_COMMAND);
   assign wr_pdown = running && SFR_WR && (SFR_ADDR == rwl_pkg::OFS_DETECTOR_POWER_DOWN);
   assign wr_auxiliary_control_two = running && SFR_WR && (SFR_ADDR == rwl_pkg::OFS_AUX_CONTROL_TWO);
   assign wr_auxiliary_control_one = running && SFR_WR && (SFR_ADDR == rwl_pkg::OFS_AUX_CONTROL_ONE);

   ////////////////////////////////////////////////////////////////////////
   // slow rc tick: rising edge of the sampled slow clock
   assign src_tick = SRC_CLK && !src_prev_ff;

   // pin reset: count slow rc ticks while the pin stays low
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         src_prev_ff <= 1'b0;
         pin_low_ticks_ff <= 2'h0;
      end else begin
         src_prev_ff <= SRC_CLK;
         if (EXT_RESET_N)
            pin_low_ticks_ff <= 2'h0;
         else if (src_tick && (pin_low_ticks_ff != 2'h3))
            pin_low_ticks_ff <= pin_low_ticks_ff + 2'h1;
      end
   end

   // a glitch no longer than one slow period never reaches the count
   assign pin_req = cfg_ff[rwl_pkg::PIN_ENABLE_BIT] &&
                    (pin_low_ticks_ff >= 2'(rwl_pkg::PIN_LOW_TICKS));

   ////////////////////////////////////////////////////////////////////////
   // detector enables: the power-down override only bites in fast mode
   assign pdown_all = in_fast && (pdown_ff == rwl_pkg::CMD_DETECT_ALL_OFF);
   assign pdown_uv = in_fast && ((pdown_ff == rwl_pkg::CMD_DETECT_ALL_OFF) ||
                                 (pdown_ff == rwl_pkg::CMD_DETECT_UV_OFF));
   // power save turns the undervoltage detector off in idle and stop
   assign UV_DETECT_EN = !pdown_uv &&
                         !(auxiliary_control_two_ff[rwl_pkg::POWER_SAVE_BIT] && in_idle_stop);
   assign POR_DETECT_EN = !pdown_all;
   assign UV_THRESH_SEL = cfg_ff[rwl_pkg::UV_SEL_LSB +: 2];
   assign POWER_SAVE = auxiliary_control_two_ff[rwl_pkg::POWER_SAVE_BIT];

   // reset sources
   assign por_req = POR_EVENT && POR_DETECT_EN;
   assign uv_req = UV_LOW && UV_DETECT_EN;
   assign soft_req = wr_cmd && (SFR_WDATA == rwl_pkg::CMD_SOFT_RESET);
   assign any_warm_req = soft_req || pin_req || wdt_req || uv_req;

   ////////////////////////////////////////////////////////////////////////
   // watchdog enable: counting in fast/slow always, idle/stop only at 11
   assign wdt_ctrl = auxiliary_control_two_ff[rwl_pkg::WDT_CTRL_LSB +: 2];
   assign wdt_rst_en = wdt_ctrl[1] && (wdt_ctrl[0] || in_fast || in_slow);
   assign wdt_run = running && (in_fast || in_slow || (wdt_ctrl == 2'h3));
   assign wdt_clear = auxiliary_control_one_ff[rwl_pkg::WDT_CLEAR_BIT];
   assign wdt_req = wdt_overflow && wdt_rst_en;
   // in stop, only the slow time base stays alive for a counting watchdog
   assign WDT_CLOCK_RUN = wdt_run;

   // watchdog counter held cleared through every chip reset
   rwl_wdt #(
      .CNT_W(15)
   ) u_wdt (
      .clk(CLOCK),
      .srst(SRST || !running),
      .tick(src_tick),
      .run(wdt_run),
      .clear(wdt_clear),
      .period_sel(option_ff[rwl_pkg::PERIOD_SEL_LSB +: 2]),
      .overflow(wdt_overflow)
   );

   ////////////////////////////////////////////////////////////////////////
   // reset sequencer next state
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      unique case (state_ff)
         rwl_pkg::ST_WARMUP: begin
            // warm-up before the configuration fetch
            if (cnt_ff >= WCNT_W'(WARMUP_CYCLES - 1)) begin
               nxt_state = rwl_pkg::ST_LOAD;
               nxt_cnt = '0;
            end else begin
               nxt_cnt = cnt_ff + WCNT_W'(1);
            end
         end
         rwl_pkg::ST_LOAD: begin
            if (load_idx_ff == 5'(rwl_pkg::CFG_BLOCK_BYTES))
               nxt_state = rwl_pkg::ST_RUN;
         end
         rwl_pkg::ST_HOLD: begin
            // a source still active restarts the hold time
            if (any_warm_req)
               nxt_cnt = '0;
            else if (cnt_ff >= WCNT_W'(HOLD_CYCLES - 1))
               nxt_state = rwl_pkg::ST_RUN;
            else
               nxt_cnt = cnt_ff + WCNT_W'(1);
         end
         rwl_pkg::ST_RUN: begin
            if (any_warm_req) begin
               nxt_state = rwl_pkg::ST_HOLD;
               nxt_cnt = '0;
            end
         end
      endcase
      // power-on event outranks everything and restarts warm-up
      if (por_req) begin
         nxt_state = rwl_pkg::ST_WARMUP;
         nxt_cnt = '0;
      end
   end

   // sequencer state
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         state_ff <= rwl_pkg::ST_WARMUP;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   assign CHIP_RESET = !running;

   ////////////////////////////////////////////////////////////////////////
   // configuration fetch: one byte per cycle, data back one cycle later
   assign FLASH_RD = (state_ff == rwl_pkg::ST_LOAD) &&
                     (load_idx_ff < 5'(rwl_pkg::CFG_BLOCK_BYTES));
   assign FLASH_ADDR = rwl_pkg::CFG_BLOCK_BASE + {12'h000, load_idx_ff[3:0]};

   // only the high configuration byte is kept by this block
   always_ff @(posedge CLOCK) begin
      if (SRST || (state_ff != rwl_pkg::ST_LOAD)) begin
         load_idx_ff <= 5'h00;
      end else if (load_idx_ff != 5'(rwl_pkg::CFG_BLOCK_BYTES)) begin
         load_idx_ff <= load_idx_ff + 5'h01;
      end
   end

   // configuration byte survives warm resets; reloaded only after power-on
   always_ff @(posedge CLOCK) begin
      if (SRST)
         cfg_ff <= rwl_pkg::RST_CONFIG_WORD;
      else if ((state_ff == rwl_pkg::ST_LOAD) &&
               (load_idx_ff == 5'(rwl_pkg::CFG_BLOCK_BYTES)))
         cfg_ff <= FLASH_RDATA;
   end
   assign CFG_WORD_HIGH = cfg_ff;

   ////////////////////////////////////////////////////////////////////////
   // control registers, back to defaults while chip reset is held
   always_ff @(posedge CLOCK) begin
      if (SRST || !running) begin
         option_ff <= rwl_pkg::RST_OPTION_CONTROL;
         pdown_ff <= rwl_pkg::RST_DETECTOR_POWER_DOWN;
         auxiliary_control_two_ff <= rwl_pkg::RST_AUX_CONTROL_TWO;
      end else begin
         if (wr_option)
            option_ff <= SFR_WDATA;
         if (wr_pdown)
            pdown_ff <= SFR_WDATA;
         if (wr_auxiliary_control_two)
            auxiliary_control_two_ff <= SFR_WDATA;
      end
   end

   // clear bit is a strobe: hardware drops it the cycle after it is set
   always_ff @(posedge CLOCK) begin
      if (SRST || !running) begin
         auxiliary_control_one_ff <= rwl_pkg::RST_AUX_CONTROL_ONE;
      end else if (wr_auxiliary_control_one) begin
         auxiliary_control_one_ff <= SFR_WDATA & (rwl_pkg::AUXILIARY_CONTROL_ONE_RW_MASK | auxiliary_control_one_clr_mask);
      end else begin
         auxiliary_control_one_ff <= auxiliary_control_one_ff & ~auxiliary_control_one_clr_mask;
      end
   end

   // time-out status must outlive the reset it causes, so of the resets only power-on clears it;
   // a new overflow beats a software clear in the same cycle
   always_ff @(posedge CLOCK) begin
      if (SRST || (state_ff == rwl_pkg::ST_WARMUP))
         wdt_status_ff <= 1'b0;
      else if (wdt_req)
         wdt_status_ff <= 1'b1;
      else if (wr_cmd && !SFR_WDATA[rwl_pkg::WDT_STATUS_BIT])
         wdt_status_ff <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; power-down register is write only and reads zero
   assign rd_sel = (SFR_ADDR == rwl_pkg::OFS_OPTION_CONTROL) ? option_ff :
                   (SFR_ADDR == rwl_pkg::OFS_SOFTWARE_COMMAND) ?
                      (8'h00 | (8'(wdt_status_ff) << rwl_pkg::WDT_STATUS_BIT)) :
                   (SFR_ADDR == rwl_pkg::OFS_AUX_CONTROL_TWO) ? auxiliary_control_two_ff :
                   (SFR_ADDR == rwl_pkg::OFS_AUX_CONTROL_ONE) ? auxiliary_control_one_ff :
                   8'h00;

   // read data registered, holds until the next read strobe
   always_ff @(posedge CLOCK) begin
      if (SRST)
         rdata_ff <= 8'h00;
      else if (SFR_RD)
         rdata_ff <= rd_sel;
   end
   assign SFR_RDATA = rdata_ff;
endmodule
`default_nettype wire

// ### sim/rwl_props.sv
`timescale 1ns/1ns
`default_nettype none
module rwl_props #(
   parameter int WARMUP_CYCLES = 50,
   parameter int HOLD_CYCLES = 16
) (
   input wire logic CLOCK, // system clock
   input wire logic SRST, // block reset
   input wire logic POR_EVENT, // power-on event
   input wire logic UV_LOW, // supply below trip level
   input wire logic [1:0] CPU_MODE, // operation mode
   input wire logic [7:0] SFR_ADDR, // register address
   input wire logic SFR_WR, // register write strobe
   input wire logic [7:0] SFR_WDATA, // register write data
   input wire logic [15:0] FLASH_ADDR, // fetch address
   input wire logic FLASH_RD, // fetch strobe
   input wire logic CHIP_RESET, // chip reset
   input wire logic [7:0] CFG_WORD_HIGH, // loaded configuration byte
   input wire logic [1:0] UV_THRESH_SEL, // trip level select
   input wire logic UV_DETECT_EN, // low-voltage detector enable
   input wire logic POR_DETECT_EN, // power-on detector enable
   input wire logic POWER_SAVE // power-save level
);
   localparam int HLO = HOLD_CYCLES - 2;
   localparam int HHI = HOLD_CYCLES + 3;
   logic [31:0] since_ff;
   logic [31:0] nxt_since;
   default clocking dck @(posedge CLOCK);
   endclocking
   default disable iff (SRST);
   ////////////////////////////////////////
   // cycles since the last power-on start; saturates so a long run never wraps
   assign nxt_since = (SRST || (POR_EVENT && POR_DETECT_EN)) ? 32'h0 :
      (since_ff == 32'hFFFFFFFF) ? since_ff : since_ff + 32'h1;
   always_ff @(posedge CLOCK) begin
      since_ff <= nxt_since;
   end
   // a taken software reset command, and the top byte of the configuration fetch
   sequence soft_cmd;
      SFR_WR && !CHIP_RESET && SFR_ADDR == rwl_pkg::OFS_SOFTWARE_COMMAND &&
         SFR_WDATA == rwl_pkg::CMD_SOFT_RESET;
   endsequence
   sequence last_fetch;
      FLASH_RD && FLASH_ADDR == rwl_pkg::CFG_WORD_HIGH_ADDR;
   endsequence
   ////////////////////////////////////////
   chk_warmup_span: assert property (
      $rose(FLASH_RD) |-> since_ff >= WARMUP_CYCLES && since_ff <= WARMUP_CYCLES + 4)
      else $error("warm-up length before the fetch is wrong");
   chk_fetch_step: assert property (
      FLASH_RD && FLASH_ADDR[3:0] != 4'hF |=> FLASH_RD && CHIP_RESET &&
         FLASH_ADDR == $past(FLASH_ADDR) + 16'h1)
      else $error("fetch address does not step through the block");
   chk_load_release: assert property (
      last_fetch |-> CHIP_RESET ##[1:3] !CHIP_RESET)
      else $error("reset not released after the last fetch");
   chk_soft_hold: assert property (
      soft_cmd |=> CHIP_RESET [*8])
      else $error("software reset not held");
   chk_soft_release: assert property (
      soft_cmd |=> ##[HLO:HHI] !CHIP_RESET)
      else $error("software reset hold length wrong");
   chk_uv_trip: assert property (
      UV_LOW && UV_DETECT_EN && !CHIP_RESET |=> CHIP_RESET)
      else $error("low supply did not reset the chip");
   chk_thresh_cfg: assert property (
      UV_THRESH_SEL == CFG_WORD_HIGH[5:4])
      else $error("trip level select differs from configuration");
   chk_slow_detect: assert property (
      CPU_MODE == rwl_pkg::MODE_SLOW && !CHIP_RESET |-> UV_DETECT_EN && POR_DETECT_EN)
      else $error("detector disabled outside fast mode");
   chk_save_idle: assert property (
      POWER_SAVE && CPU_MODE == rwl_pkg::MODE_IDLE |-> !UV_DETECT_EN)
      else $error("power save left the detector on in idle");
endmodule
`default_nettype wire

// ### sim/rwl_partner.sv
`timescale 1ns/1ns
`default_nettype none
module rwl_partner (
   input wire logic clk, // system clock
   input wire logic [15:0] flash_addr, // fetch address
   input wire logic flash_rd, // fetch strobe
   input wire logic [7:0] cfg_byte, // high configuration byte to serve
   output logic [7:0] flash_rdata, // fetch data, one cycle after strobe
   output logic src_clk // slow rc level, sped up to keep runs short
);
   logic [1:0] div_ff = 2'h0;
   logic [7:0] data_ff = 8'h00;
   logic [7:0] nxt_data;
   ////////////////////////////////////////
   // idle bus flips every cycle so a late capture never sees a stale byte
   assign nxt_data = !flash_rd ? ~data_ff :
      (flash_addr == 16'h1FFF) ? cfg_byte : {4'hC, flash_addr[3:0]};
   always_ff @(posedge clk) begin
      data_ff <= nxt_data;
      div_ff <= div_ff + 2'h1;
   end
   assign flash_rdata = data_ff;
   // free-running oscillator, one tick every four system cycles
   assign src_clk = div_ff[1];
endmodule
`default_nettype wire

// ### sim/reset_watchdog_lvr_control_test.sv
`timescale 1ns/1ns
`default_nettype none
module reset_watchdog_lvr_control_test;
   localparam int WARM = 50; // shortened warm-up
   localparam int TCYC = 4; // system cycles per slow tick
   localparam int WDC = rwl_pkg::WDT_TICKS_SEL3 * TCYC;
   logic CLOCK = 1'b0;
   logic SRST = 1'b1;
   logic POR_EVENT = 1'b0;
   logic UV_LOW = 1'b0;
   logic EXT_RESET_N = 1'b1;
   logic [1:0] CPU_MODE = 2'h0;
   logic [7:0] SFR_ADDR = 8'h00;
   logic SFR_WR = 1'b0;
   logic SFR_RD = 1'b0;
   logic [7:0] SFR_WDATA = 8'h00;
   logic [7:0] cfg_byte = 8'h20;
   logic [7:0] SFR_RDATA, FLASH_RDATA, CFG_WORD_HIGH;
   logic [15:0] FLASH_ADDR;
   logic [1:0] UV_THRESH_SEL;
   logic SRC_CLK, FLASH_RD, CHIP_RESET, UV_DETECT_EN, POR_DETECT_EN, POWER_SAVE, WDT_CLOCK_RUN;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;
   int n;
   logic [7:0] addrs [6] = '{8'h94, 8'hF7, 8'hF8, 8'h97, 8'hE5, 8'h90};
   logic [7:0] defs [6] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] wbacks [6] = '{8'hFF, 8'hFF, 8'h5D, 8'h00, 8'h00, 8'h00};
   always #50 CLOCK = ~CLOCK;
   rwl_reset_ctrl #(.WARMUP_CYCLES(WARM)) DUT (.CLOCK(CLOCK), .SRST(SRST),
      .POR_EVENT(POR_EVENT), .UV_LOW(UV_LOW), .EXT_RESET_N(EXT_RESET_N), .SRC_CLK(SRC_CLK),
      .CPU_MODE(CPU_MODE), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
      .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .FLASH_ADDR(FLASH_ADDR),
      .FLASH_RD(FLASH_RD), .FLASH_RDATA(FLASH_RDATA), .CHIP_RESET(CHIP_RESET),
      .CFG_WORD_HIGH(CFG_WORD_HIGH), .UV_THRESH_SEL(UV_THRESH_SEL),
      .UV_DETECT_EN(UV_DETECT_EN), .POR_DETECT_EN(POR_DETECT_EN),
      .POWER_SAVE(POWER_SAVE), .WDT_CLOCK_RUN(WDT_CLOCK_RUN));
   rwl_partner u_partner (.clk(CLOCK), .flash_addr(FLASH_ADDR), .flash_rd(FLASH_RD),
      .cfg_byte(cfg_byte), .flash_rdata(FLASH_RDATA), .src_clk(SRC_CLK));
   ////////////////////////////////////////
   // compare, bus access and wait helpers; a write spans two edges, a read three
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      SFR_ADDR <= a;
      SFR_WDATA <= d;
      SFR_WR <= 1'b1;
      @(posedge CLOCK);
      SFR_WR <= 1'b0;
      #1;
   endtask
   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLOCK);
      SFR_ADDR <= a;
      SFR_RD <= 1'b1;
      @(posedge CLOCK);
      SFR_RD <= 1'b0;
      @(posedge CLOCK);
      #1;
      check(SFR_RDATA, exp);
   endtask
   // bounded wait for the chip reset level; a limit that runs out is a mismatch
   task automatic wait_rst(input logic lvl, input int limit, output int cnt);
      cnt = 0;
      while (CHIP_RESET !== lvl && cnt < limit) begin
         @(posedge CLOCK);
         #1;
         cnt++;
      end
      check(CHIP_RESET, lvl);
   endtask
   task automatic set_mode(input logic [1:0] m);
      @(posedge CLOCK);
      CPU_MODE <= m;
      @(posedge CLOCK);
      #1;
   endtask
   task automatic rd_defaults();
      for (int i = 0; i < 6; i++) begin
         sfr_rd(addrs[i], defs[i]);
      end
   endtask
   task automatic por_load(input logic [7:0] c);
      @(posedge CLOCK);
      cfg_byte <= c;
      POR_EVENT <= 1'b1;
      @(posedge CLOCK);
      POR_EVENT <= 1'b0;
      #1;
      check(CHIP_RESET, 1'b1);
      wait_rst(1'b0, WARM + 40, n);
      check(n > WARM + 12, 1'b1);
      check(CFG_WORD_HIGH, c);
      check(UV_THRESH_SEL, c[5:4]);
   endtask
   task automatic done(input string s);
      $display("test finished: %s", s);
   endtask
   task automatic wrap_up();
      $display("checks %0d, miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // hang guard, well above the expected run length
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         wrap_up();
      end
   end
   ////////////////////////////////////////
   initial begin
      repeat (10) @(posedge CLOCK);
      SRST <= 1'b0;
      @(posedge CLOCK);
      #1;
      wait_rst(1'b0, WARM + 40, n);
      check(n >= WARM + 16 && n <= WARM + 20, 1'b1);
      check(CFG_WORD_HIGH, 8'h20);
      rd_defaults();
      done("power-on load and defaults");
      for (int i = 0; i < 6; i++) begin
         if (i != 3) begin
            sfr_wr(addrs[i], 8'hFF);
            sfr_rd(addrs[i], wbacks[i]);
         end
      end
      sfr_wr(8'h97, 8'h56);
      check(CHIP_RESET, 1'b1);
      wait_rst(1'b0, 40, n);
      rd_defaults();
      done("register access and software reset");
      // pin held low well past two ticks while the configuration disables it
      @(posedge CLOCK);
      EXT_RESET_N <= 1'b0;
      repeat (12 * TCYC) @(posedge CLOCK);
      #1;
      check(CHIP_RESET, 1'b0);
      @(posedge CLOCK);
      EXT_RESET_N <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         por_load({2'h1, 2'(k), 4'h0});
      end
      @(posedge CLOCK);
      EXT_RESET_N <= 1'b0;
      wait_rst(1'b1, 4 * TCYC, n);
      check(n >= TCYC - 1, 1'b1);
      @(posedge CLOCK);
      EXT_RESET_N <= 1'b1;
      wait_rst(1'b0, 40, n);
      done("pin reset and power-on reload");
      @(posedge CLOCK);
      UV_LOW <= 1'b1;
      @(posedge CLOCK);
      UV_LOW <= 1'b0;
      #1;
      check(CHIP_RESET, 1'b1);
      wait_rst(1'b0, 40, n);
      sfr_wr(8'hE5, 8'h38);
      check({UV_DETECT_EN, POR_DETECT_EN}, 2'h1);
      @(posedge CLOCK);
      UV_LOW <= 1'b1;
      repeat (3) @(posedge CLOCK);
      UV_LOW <= 1'b0;
      #1;
      check(CHIP_RESET, 1'b0);
      sfr_wr(8'hE5, 8'h37);
      check({UV_DETECT_EN, POR_DETECT_EN}, 2'h0);
      set_mode(rwl_pkg::MODE_SLOW);
      check({UV_DETECT_EN, POR_DETECT_EN}, 2'h3);
      set_mode(rwl_pkg::MODE_IDLE);
      sfr_wr(8'hF7, 8'h26);
      check({POWER_SAVE, UV_DETECT_EN}, 2'h2);
      set_mode(rwl_pkg::MODE_STOP);
      sfr_wr(8'hF7, 8'h80);
      check(WDT_CLOCK_RUN, 1'b0);
      sfr_wr(8'hF7, 8'hC0);
      check(WDT_CLOCK_RUN, 1'b1);
      set_mode(rwl_pkg::MODE_FAST);
      sfr_wr(8'h97, 8'h56);
      wait_rst(1'b0, 40, n);
      check(UV_DETECT_EN, 1'b1);
      done("detectors and modes");
      // shortest period, reset in all modes; a mid-way clear restarts the count
      sfr_wr(8'h94, 8'h30);
      sfr_wr(8'hF7, 8'hC6);
      sfr_wr(8'hF8, 8'h80);
      repeat (10000) @(posedge CLOCK);
      sfr_wr(8'hF8, 8'h80);
      check(CHIP_RESET, 1'b0);
      wait_rst(1'b1, WDC + 1000, n);
      check(n >= WDC - 100 && n <= WDC + 100, 1'b1);
      wait_rst(1'b0, 40, n);
      sfr_rd(8'h97, 8'h02);
      sfr_rd(8'h94, 8'h00);
      sfr_wr(8'h97, 8'h00);
      sfr_rd(8'h97, 8'h00);
      done("watchdog");
      wrap_up();
   end
endmodule
bind rwl_reset_ctrl rwl_props #(.WARMUP_CYCLES(WARMUP_CYCLES), .HOLD_CYCLES(HOLD_CYCLES))
   u_props (.CLOCK(CLOCK), .SRST(SRST), .POR_EVENT(POR_EVENT), .UV_LOW(UV_LOW),
   .CPU_MODE(CPU_MODE), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA),
   .FLASH_ADDR(FLASH_ADDR), .FLASH_RD(FLASH_RD), .CHIP_RESET(CHIP_RESET),
   .CFG_WORD_HIGH(CFG_WORD_HIGH), .UV_THRESH_SEL(UV_THRESH_SEL),
   .UV_DETECT_EN(UV_DETECT_EN), .POR_DETECT_EN(POR_DETECT_EN), .POWER_SAVE(POWER_SAVE));
`default_nettype wire
